// ===== rtl/pwr_rst_pkg.sv
package pwr_rst_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int NOISE_NS = 7000;
  localparam int NOISE_CYC = (NOISE_NS * CLK_MHZ + 999) / 1000;
  localparam int LFO_KHZ = 125;
  localparam int LFO_TICK_CYC = (CLK_MHZ * 1000) / LFO_KHZ;
  localparam int CFG_PRESCALE = 32;
  localparam int CFG_TICKS = 'h30;
  localparam int CFG_MS = 12;
  localparam int CFG_LFO_TICKS = CFG_PRESCALE * CFG_TICKS;
  localparam int STAB_MS = 16;
  localparam int STAB_CYC = STAB_MS * CLK_MHZ * 1000;
  localparam int WAKE_MS = 20;
  localparam int WAKE_CYC = WAKE_MS * CLK_MHZ * 1000;
  localparam int SEQ_CLKS = 5;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] IDX_RSTCTL = 8'h86;
  localparam logic [7:0] IDX_PMCTL = 8'h87;
  localparam logic [7:0] IDX_STAT = 8'h88;
  localparam logic [31:0] ADDR_RSTCTL = {22'h0, IDX_RSTCTL, 2'h0};
  localparam logic [31:0] ADDR_PMCTL = {22'h0, IDX_PMCTL, 2'h0};
  localparam logic [31:0] ADDR_STAT = {22'h0, IDX_STAT, 2'h0};
  localparam logic [7:0] RSTCTL_RST = 8'h81;
  localparam logic [7:0] PMCTL_RST = 8'h00;
  localparam logic [7:0] PMCTL_IDLE = 8'h01;
  localparam logic [7:0] PMCTL_STOP = 8'h03;
  localparam int POS_PWRONF = 7;
  localparam int POS_PINF = 6;
  localparam int POS_WDOGF = 5;
  localparam int POS_DBGRF = 4;
  localparam int POS_BROWNF = 3;
  localparam int POS_BROWNEN = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ************************************************************
  // core reset values
  // ************************************************************
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [15:0] RST_VECTOR_ADDR = 16'h0000;

  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [3:0] {
    RST_CFG = 4'b0001,
    RST_HOLD = 4'b0010,
    RST_SEQ = 4'b0100,
    RST_RUN = 4'b1000
  } rst_state_e;

  typedef enum logic [3:0] {
    PM_RUN = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_STOP = 4'b0100,
    PM_WAKE = 4'b1000
  } pwr_mode_e;

endpackage : pwr_rst_pkg

// ===== rtl/power_mode_and_reset_control.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module power_mode_and_reset_control
  import pwr_rst_pkg::*;
#(
  parameter int N_IRQ = 8,
  parameter int NOISE_CYCLES = NOISE_CYC,
  parameter int LFO_TICK_CYCLES = LFO_TICK_CYC,
  parameter int STAB_CYCLES = STAB_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic externalResetPinN,
  input wire logic powerOnDetect,
  input wire logic brownoutTrip,
  input wire logic watchdogOverflow,
  input wire logic watchdogResetEnable,
  input wire logic debugPortResetReq,
  input wire logic cfgExtResetPinEnable,
  input wire logic stopKeepLowFreq,
  input wire logic globalInterruptEnable,
  input wire logic [N_IRQ-1:0] interruptEnable,
  input wire logic [N_IRQ-1:0] interruptRequest,
  output logic sysResetN,
  output logic configReadStrobe,
  output logic extResetPinIsGpio,
  output logic cpuHalt,
  output logic sysClkEnable,
  output logic periphClkEnable,
  output logic mainOscEnable,
  output logic lowFreqOscEnable,
  output logic intervalTimerRun,
  output logic brownoutEnable,
  output logic [1:0] brownoutLevelSelect,
  output logic [N_IRQ-1:0] wakeInterrupt,
  output logic [15:0] resetPcValue,
  output logic [7:0] resetAccValue,
  output logic [7:0] resetSpValue,
  output logic [15:0] resetVectorAddr
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (N_IRQ < 1 || N_IRQ > 32 || NOISE_CYCLES < 1 || LFO_TICK_CYCLES < 1 ||
      STAB_CYCLES < 2 || WAKE_CYCLES < 2) begin : g_badParam
    $error("power_mode_and_reset_control: parameter out of range");
  end

  localparam int NW = $clog2(NOISE_CYCLES + 1);
  localparam int LW = $clog2(LFO_TICK_CYCLES + 1);
  localparam int CW = $clog2(CFG_LFO_TICKS + 1);

  // ************************************************************
  // reset pin noise filter
  // ************************************************************
  logic [NW-1:0] lowCnt_q;
  logic extPinEn_q;
  logic extRst;
  logic wdtRst;
  logic brownRst;
  logic srcAny;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt_q <= '0;
    end else if (externalResetPinN || !extPinEn_q) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q != NW'(NOISE_CYCLES)) begin
      lowCnt_q <= lowCnt_q + NW'(1);
    end
  end

  logic [7:0] rstCtl_q;
  assign extRst = (lowCnt_q == NW'(NOISE_CYCLES));
  assign wdtRst = watchdogOverflow && watchdogResetEnable;
  assign brownRst = brownoutTrip && rstCtl_q[POS_BROWNEN];
  assign srcAny = extRst || powerOnDetect || wdtRst || brownRst || debugPortResetReq;

  // ************************************************************
  // low-frequency tick divider
  // ************************************************************
  logic [LW-1:0] lfoDiv_q;
  logic lfoTick;
  assign lfoTick = (lfoDiv_q == LW'(LFO_TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lfoDiv_q <= '0;
    end else if (lfoTick) begin
      lfoDiv_q <= '0;
    end else begin
      lfoDiv_q <= lfoDiv_q + LW'(1);
    end
  end

  // ************************************************************
  // reset sequencer
  // ************************************************************
  rst_state_e rst_q, rst_d;
  logic [CW-1:0] cfgCnt_q, cfgCnt_d;
  logic [31:0] stabCnt_q, stabCnt_d;
  logic [2:0] seqCnt_q, seqCnt_d;
  logic cfgRead;

  always_comb begin
    rst_d = rst_q;
    cfgCnt_d = cfgCnt_q;
    stabCnt_d = srcAny ? '0 : stabCnt_q + 32'h1;
    seqCnt_d = '0;
    cfgRead = 1'b0;
    case (rst_q)
      RST_CFG: begin
        if (lfoTick) begin
          cfgCnt_d = cfgCnt_q + CW'(1);
        end
        if (lfoTick && cfgCnt_q == CW'(CFG_LFO_TICKS - 1)) begin
          cfgRead = 1'b1;
          rst_d = RST_HOLD;
        end
      end
      RST_HOLD: begin
        if (!srcAny && stabCnt_q >= 32'(STAB_CYCLES - 1)) begin
          rst_d = RST_SEQ;
        end
      end
      RST_SEQ: begin
        seqCnt_d = seqCnt_q + 3'h1;
        if (srcAny) begin
          rst_d = RST_HOLD;
        end else if (seqCnt_q == 3'(SEQ_CLKS - 1)) begin
          rst_d = RST_RUN;
        end
      end
      RST_RUN: begin
        if (srcAny) begin
          rst_d = RST_HOLD;
        end
      end
      default: begin
        rst_d = RST_HOLD;
      end
    endcase
    if (powerOnDetect) begin
      rst_d = RST_CFG;
      cfgCnt_d = '0;
    end
    if (rst_d == RST_RUN) begin
      stabCnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= RST_CFG;
      cfgCnt_q <= '0;
      stabCnt_q <= '0;
      seqCnt_q <= '0;
      sysResetN <= 1'b0;
      configReadStrobe <= 1'b0;
    end else begin
      rst_q <= rst_d;
      cfgCnt_q <= cfgCnt_d;
      stabCnt_q <= stabCnt_d;
      seqCnt_q <= seqCnt_d;
      sysResetN <= (rst_d == RST_RUN);
      configReadStrobe <= cfgRead;
    end
  end

  // pin becomes plain i/o when the option read says so
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      extPinEn_q <= 1'b1;
    end else if (cfgRead) begin
      extPinEn_q <= cfgExtResetPinEnable;
    end
  end
  assign extResetPinIsGpio = !extPinEn_q;

  // ************************************************************
  // bus slave
  // ************************************************************
  logic addrOk;
  logic dpWrite_q;
  logic [31:0] dpAddr_q;
  logic wrRstCtl;
  logic wrPmCtl;
  logic [7:0] pmCtl_q, pmCtl_d;
  logic [7:0] rstCtl_d;
  logic [7:0] statusVal;
  logic [7:0] rdVal;
  pwr_mode_e mode_q, mode_d;
  logic wakeReq;
  logic stopVariant_q;

  assign addrOk = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wrRstCtl = dpWrite_q && dpAddr_q == ADDR_RSTCTL;
  assign wrPmCtl = dpWrite_q && dpAddr_q == ADDR_PMCTL;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dpWrite_q <= 1'b0;
      dpAddr_q <= '0;
    end else if (hready) begin
      dpWrite_q <= addrOk && hwrite;
      dpAddr_q <= {haddr[31:2], 2'h0};
    end
  end

  assign statusVal = {1'b0, stopVariant_q, mode_q == PM_WAKE, mode_q == PM_STOP,
                      mode_q == PM_IDLE, extResetPinIsGpio, rst_q != RST_CFG, sysResetN};

  always_comb begin
    rdVal = 8'h00;
    case ({haddr[31:2], 2'h0})
      ADDR_RSTCTL: rdVal = rstCtl_d;
      ADDR_PMCTL: rdVal = pmCtl_d;
      ADDR_STAT: rdVal = statusVal;
      default: rdVal = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= '0;
    end else if (addrOk && !hwrite) begin
      hrdata <= {24'h0, rdVal};
    end
  end

  // ************************************************************
  // reset cause and brown-out control
  // ************************************************************
  always_comb begin
    rstCtl_d = rstCtl_q;
    if (wrRstCtl) begin
      rstCtl_d[7:3] = rstCtl_q[7:3] & hwdata[7:3];
      rstCtl_d[2:0] = hwdata[2:0];
    end
    if (srcAny) begin
      rstCtl_d[2:0] = RSTCTL_RST[2:0];
    end
    if (powerOnDetect) begin
      rstCtl_d[7:3] = 5'h10;
    end else begin
      rstCtl_d[POS_PINF] = rstCtl_d[POS_PINF] | extRst;
      rstCtl_d[POS_WDOGF] = rstCtl_d[POS_WDOGF] | wdtRst;
      rstCtl_d[POS_DBGRF] = rstCtl_d[POS_DBGRF] | debugPortResetReq;
      rstCtl_d[POS_BROWNF] = rstCtl_d[POS_BROWNF] | brownRst;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstCtl_q <= RSTCTL_RST;
    end else begin
      rstCtl_q <= rstCtl_d;
    end
  end
  assign brownoutEnable = rstCtl_q[POS_BROWNEN];
  assign brownoutLevelSelect = rstCtl_q[2:1];

  // ************************************************************
  // power mode control
  // ************************************************************
  assign wakeReq = globalInterruptEnable && |(interruptRequest & interruptEnable);

  always_comb begin
    pmCtl_d = pmCtl_q;
    if (wrPmCtl) begin
      pmCtl_d = hwdata[7:0];
    end
    if ((mode_q == PM_STOP || mode_q == PM_IDLE) && wakeReq) begin
      pmCtl_d = PMCTL_RST;
    end
    if (srcAny || !sysResetN) begin
      pmCtl_d = PMCTL_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pmCtl_q <= PMCTL_RST;
    end else begin
      pmCtl_q <= pmCtl_d;
    end
  end

  logic [31:0] wakeCnt_q;
  logic [N_IRQ-1:0] wakeSrc_q;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PM_RUN: begin
        if (pmCtl_q == PMCTL_IDLE) begin
          mode_d = PM_IDLE;
        end else if (pmCtl_q == PMCTL_STOP) begin
          mode_d = PM_STOP;
        end
      end
      PM_IDLE: begin
        if (wakeReq) begin
          mode_d = PM_RUN;
        end
      end
      PM_STOP: begin
        if (wakeReq) begin
          mode_d = PM_WAKE;
        end
      end
      PM_WAKE: begin
        if (wakeCnt_q == 32'(WAKE_CYCLES - 1)) begin
          mode_d = PM_RUN;
        end
      end
      default: begin
        mode_d = PM_RUN;
      end
    endcase
    if (srcAny || !sysResetN) begin
      mode_d = PM_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= PM_RUN;
      wakeCnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      wakeCnt_q <= (mode_q == PM_WAKE && mode_d == PM_WAKE) ? wakeCnt_q + 32'h1 : '0;
    end
  end

  // interrupt enables live outside and are never touched here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wakeSrc_q <= '0;
      wakeInterrupt <= '0;
    end else begin
      if ((mode_q == PM_STOP || mode_q == PM_IDLE) && mode_d != PM_RUN) begin
        wakeSrc_q <= interruptRequest & interruptEnable;
      end else if (mode_q == PM_IDLE && mode_d == PM_RUN) begin
        wakeSrc_q <= interruptRequest & interruptEnable;
      end
      if (mode_q == PM_WAKE && mode_d == PM_RUN) begin
        wakeInterrupt <= wakeSrc_q;
      end else if (mode_q == PM_IDLE && mode_d == PM_RUN && sysResetN) begin
        wakeInterrupt <= interruptRequest & interruptEnable;
      end else begin
        wakeInterrupt <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stopVariant_q <= 1'b0;
    end else if (mode_q == PM_RUN && mode_d == PM_STOP) begin
      stopVariant_q <= stopKeepLowFreq;
    end
  end

  // ************************************************************
  // clock and oscillator enables
  // ************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpuHalt <= 1'b0;
      sysClkEnable <= 1'b1;
      periphClkEnable <= 1'b1;
      mainOscEnable <= 1'b1;
      lowFreqOscEnable <= 1'b1;
      intervalTimerRun <= 1'b0;
    end else begin
      cpuHalt <= mode_d != PM_RUN;
      sysClkEnable <= mode_d != PM_STOP && mode_d != PM_WAKE;
      periphClkEnable <= mode_d == PM_RUN || mode_d == PM_IDLE;
      mainOscEnable <= mode_d != PM_STOP;
      lowFreqOscEnable <= !(mode_d == PM_STOP && !(mode_q == PM_RUN ? stopKeepLowFreq : stopVariant_q));
      intervalTimerRun <= mode_d == PM_WAKE || rst_d == RST_HOLD;
    end
  end

  assign resetPcValue = RST_PC;
  assign resetAccValue = RST_ACC;
  assign resetSpValue = RST_SP;
  assign resetVectorAddr = RST_VECTOR_ADDR;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_idle_entry: assert property ((mode_q == PM_RUN && pmCtl_q == PMCTL_IDLE && sysResetN && !srcAny)
    |=> mode_q == PM_IDLE && cpuHalt && periphClkEnable) else $error("idle not entered");
  a_stop_entry: assert property ((mode_q == PM_RUN && pmCtl_q == PMCTL_STOP && sysResetN && !srcAny)
    |=> mode_q == PM_STOP && !sysClkEnable && !periphClkEnable) else $error("stop not entered");
  a_stop_selfclear: assert property ((mode_q == PM_STOP && (wakeReq || srcAny) && !wrPmCtl)
    |=> pmCtl_q == PMCTL_RST) else $error("mode control not cleared");
  a_stop_variant: assert property ((mode_q == PM_STOP && $past(mode_q) == PM_STOP && !srcAny && !wakeReq)
    |=> lowFreqOscEnable == stopVariant_q && !mainOscEnable) else $error("wrong stop variant");
  a_stop_hold: assert property ((mode_q == PM_STOP && !wakeReq && !srcAny && sysResetN)
    |=> mode_q == PM_STOP) else $error("stop left without interrupt");
  a_noise_filter: assert property ($rose(extRst) |-> $past(!externalResetPinN, 1) && $past(!externalResetPinN, 2))
    else $error("reset pin not filtered");
  a_flag_sticky: assert property ((rstCtl_q[POS_WDOGF] && !powerOnDetect && !wrRstCtl)
    |=> rstCtl_q[POS_WDOGF]) else $error("reset history lost");
  a_por_flag: assert property (powerOnDetect |=> rstCtl_q[POS_PWRONF] && !rstCtl_q[POS_PINF] && rstCtl_q[POS_BROWNEN])
    else $error("power-on flag wrong");
  a_reset_hold: assert property (srcAny |=> !sysResetN ##1 !sysResetN) else $error("reset released early");
  a_seq_five: assert property (($rose(rst_q == RST_SEQ) ##0 (!srcAny)[*5]) |=> rst_q == RST_RUN && sysResetN)
    else $error("sequence not five clocks");
  c_idle_wake: cover property (mode_q == PM_IDLE ##1 mode_q == PM_RUN);
  c_stop_wake: cover property (mode_q == PM_WAKE ##1 mode_q == PM_RUN);
  c_ext_reset: cover property ($rose(extRst) ##[1:1000] $rose(sysResetN));

endmodule : power_mode_and_reset_control

// ===== dv/supply_pin_model.sv
`timescale 1ns/1ns
// ************************************************************
// reset pin and supply monitor
// ************************************************************
module supply_pin_model (
  input wire logic clk_sys,
  output logic externalResetPinN,
  output logic powerOnDetect,
  output logic brownoutTrip
);
  initial begin
    externalResetPinN = 1'b1;
    powerOnDetect = 1'b0;
    brownoutTrip = 1'b0;
  end

  // which: 0 pin low, 1 power-on, 2 brown-out; held n cycles
  task automatic pulse(input int which, input int n);
    @(posedge clk_sys);
    if (which == 0) begin
      externalResetPinN <= 1'b0;
    end else if (which == 1) begin
      powerOnDetect <= 1'b1;
    end else begin
      brownoutTrip <= 1'b1;
    end
    repeat (n) @(posedge clk_sys);
    externalResetPinN <= 1'b1;
    powerOnDetect <= 1'b0;
    brownoutTrip <= 1'b0;
  endtask : pulse
endmodule : supply_pin_model

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb
  import pwr_rst_pkg::*;
;
  localparam int NC = 4;
  localparam int LC = 2;
  localparam int SC = 50;
  localparam int WC = 20;
  logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, brownLvl;
  logic [2:0] hsize;
  logic pinN, por, brown, wdov, wden, dbg, cfg, keep, gie;
  logic [7:0] irqEn, ireq, wakeI, rAcc, rSp;
  logic sysResetN, cfgStrobe, gpio, cpuHalt, sysClk, perClk, mOsc, lOsc, itRun, brownEn;
  logic [15:0] rPc, rVec;
  int n_mismatch, samples_checked, n;

  supply_pin_model u_supply_pin_model (.clk_sys(clk_sys), .externalResetPinN(pinN), .powerOnDetect(por),
    .brownoutTrip(brown));

  power_mode_and_reset_control #(.NOISE_CYCLES(NC), .LFO_TICK_CYCLES(LC), .STAB_CYCLES(SC), .WAKE_CYCLES(WC))
  u_power_mode_and_reset_control (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .externalResetPinN(pinN), .powerOnDetect(por),
    .brownoutTrip(brown), .watchdogOverflow(wdov), .watchdogResetEnable(wden), .debugPortResetReq(dbg),
    .cfgExtResetPinEnable(cfg), .stopKeepLowFreq(keep), .globalInterruptEnable(gie), .interruptEnable(irqEn),
    .interruptRequest(ireq), .sysResetN(sysResetN), .configReadStrobe(cfgStrobe), .extResetPinIsGpio(gpio),
    .cpuHalt(cpuHalt), .sysClkEnable(sysClk), .periphClkEnable(perClk), .mainOscEnable(mOsc),
    .lowFreqOscEnable(lOsc), .intervalTimerRun(itRun), .brownoutEnable(brownEn), .brownoutLevelSelect(brownLvl),
    .wakeInterrupt(wakeI), .resetPcValue(rPc), .resetAccValue(rAcc), .resetSpValue(rSp),
    .resetVectorAddr(rVec));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd

  task automatic wait_rst(output int k);
    k = 0;
    while (sysResetN !== 1'b1 && k < 5000) begin
      cyc(1);
      k++;
    end
  endtask : wait_rst

  task automatic hit(input int k);
    @(posedge clk_sys);
    if (k == 0) wdov <= 1'b1;
    else dbg <= 1'b1;
    @(posedge clk_sys);
    wdov <= 1'b0;
    dbg <= 1'b0;
  endtask : hit

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_boot();
    chk({rPc, rVec}, {RST_PC, RST_VECTOR_ADDR});
    chk({rAcc, rSp, 5'h0, brownEn, perClk, sysResetN}, {RST_ACC, RST_SP, 8'h06});
    rd(ADDR_RSTCTL, 32'h81);
    rd(ADDR_PMCTL, 32'h00);
    n = 0;
    while (cfgStrobe !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= CFG_LFO_TICKS * LC - 8 && n <= CFG_LFO_TICKS * LC + 8), 32'h1);
    wait_rst(n);
    chk(32'(n >= SEQ_CLKS - 1 && n <= SEQ_CLKS + 4), 32'h1);
    chk(gpio, 1'b0);
    $display("test boot done");
  endtask : t_boot

  task automatic t_flags();
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RSTCTL, {29'h0, i[1:0], 1'b1});
      cyc(2);
      chk(brownLvl, i[1:0]);
    end
    wr(ADDR_RSTCTL, 32'h06);
    cyc(2);
    chk(brownEn, 1'b0);
    wr(ADDR_RSTCTL, 32'h07);
    rd(ADDR_RSTCTL, 32'h07);
    wr(32'h400, 32'hff);
    rd(32'h400, 32'h0);
    $display("test flags done");
  endtask : t_flags

  task automatic t_idle();
    wr(ADDR_PMCTL, PMCTL_IDLE);
    cyc(3);
    chk({cpuHalt, sysClk, perClk, mOsc, lOsc}, 5'h1f);
    @(posedge clk_sys);
    irqEn <= 8'h04;
    ireq <= 8'h04;
    gie <= 1'b1;
    n = 0;
    cyc(1);
    while (wakeI === 8'h00 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(wakeI, 8'h04);
    cyc(2);
    chk(cpuHalt, 1'b0);
    @(posedge clk_sys);
    ireq <= 8'h00;
    gie <= 1'b0;
    $display("test idle done");
  endtask : t_idle

  task automatic t_stop();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys);
      keep <= v[0];
      irqEn <= 8'h10;
      ireq <= 8'h10;
      wr(ADDR_PMCTL, PMCTL_STOP);
      cyc(3);
      chk({cpuHalt, sysClk, perClk, mOsc, lOsc}, {4'h8, v[0]});
      rd(ADDR_PMCTL, 32'h03);
      @(posedge clk_sys);
      gie <= 1'b1;
      cyc(3);
      chk({itRun, sysClk, cpuHalt}, 3'h5);
      rd(ADDR_PMCTL, 32'h00);
      n = 0;
      while (wakeI === 8'h00 && n < 40) begin
        cyc(1);
        n++;
      end
      chk(wakeI, 8'h10);
      cyc(2);
      chk({sysClk, perClk, cpuHalt}, 3'h6);
      @(posedge clk_sys);
      ireq <= 8'h00;
      gie <= 1'b0;
    end
    $display("test stop done");
  endtask : t_stop

  task automatic t_ext();
    wr(ADDR_PMCTL, PMCTL_STOP);
    u_supply_pin_model.pulse(0, NC - 1);
    cyc(6);
    chk(sysResetN, 1'b1);
    u_supply_pin_model.pulse(0, NC + 6);
    #1;
    chk(sysResetN, 1'b0);
    wait_rst(n);
    chk(32'(n >= SC && n <= SC + SEQ_CLKS + 4), 32'h1);
    rd(ADDR_PMCTL, 32'h00);
    rd(ADDR_RSTCTL, 32'h41);
    $display("test external reset done");
  endtask : t_ext

  task automatic t_src();
    hit(0);
    cyc(4);
    chk(sysResetN, 1'b1);
    @(posedge clk_sys);
    wden <= 1'b1;
    hit(0);
    cyc(2);
    chk(sysResetN, 1'b0);
    wait_rst(n);
    rd(ADDR_RSTCTL, 32'h61);
    hit(1);
    cyc(2);
    chk(sysResetN, 1'b0);
    wait_rst(n);
    rd(ADDR_RSTCTL, 32'h71);
    wr(ADDR_RSTCTL, 32'h78);
    u_supply_pin_model.pulse(2, 3);
    cyc(4);
    chk({sysResetN, brownEn}, 2'h2);
    wr(ADDR_RSTCTL, 32'h79);
    u_supply_pin_model.pulse(2, 3);
    #1;
    chk(sysResetN, 1'b0);
    wait_rst(n);
    rd(ADDR_RSTCTL, 32'h79);
    $display("test sources done");
  endtask : t_src

  task automatic t_por();
    @(posedge clk_sys);
    cfg <= 1'b0;
    u_supply_pin_model.pulse(1, 3);
    #1;
    chk(sysResetN, 1'b0);
    rd(ADDR_RSTCTL, 32'h81);
    wait_rst(n);
    chk({gpio, brownEn, sysResetN}, 3'h7);
    $display("test power-on done");
  endtask : t_por

  // ************************************************************
  // run
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #(8 * 40000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {arst_n, hsel, hwrite, wdov, wden, dbg, keep, gie} = 8'h0;
    cfg = 1'b1;
    {haddr, hwdata, htrans, hsize, irqEn, ireq} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    cyc(1);
    t_boot();
    t_flags();
    t_idle();
    t_stop();
    t_ext();
    t_src();
    t_por();
    finish_test();
  end
endmodule : tb
